// File: logic/apm_aux_pin.sv
// Function mux and interrupt signalling for one auxiliary pin (aux_pin_b).
// Assumes detectors and flag-read strobe on ref_clk; pad input asynchronous.
// Function
// R1: Selector 0000 (reset) leaves pin disabled.
// R2: Host never writes reserved code 0001.
// R3: Code 0010 drives headset interrupt, 1.75 ms.
// R4: Code 0011 is input; D2 shows level.
// R5: Code 0100 is output; drives D3 value.
// R6: Codes 0101-0111 take microphone data, both edges.
// R7: Code 1000 carries bit clock, direction separate.
// R8: Code 1001 outputs headset OR button.
// R9: Code 1010 outputs OR of all four.
// R10: Code 1011 outputs short OR noise.
// R11: Code 1100 outputs headset, button, short OR.
// R12: Code 1101 outputs short-circuit only.
// R13: Code 1111 outputs button only.
// R14: Code 1110 outputs noise only, assumed.
// R15: D1 zero gives one 2 ms pulse.
// R16: D1 one repeats pulses until flags read.
// R17: Host never writes D0; reads zero.
// R18: Driver off unless output, interrupt, bit clock.
`timescale 1ns/10ps
`default_nettype none
module apm_aux_pin #(
   parameter int unsigned PULSE_CYCLES = apm_pkg::PULSE_CYC, // 2 ms pulse
   parameter int unsigned HS_CYCLES = apm_pkg::HS_PULSE_CYC // 1.75 ms pulse
) (
   input wire logic ref_clk, // 10 MHz clock
   input wire logic rst_n, // Synchronous reset, low
   input wire logic [9:0] avs_address, // Byte address
   input wire logic avs_read, // Read request
   input wire logic avs_write, // Write request
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [3:0] avs_byteenable, // Byte lanes
   output logic [31:0] avs_readdata, // Read data
   output logic avs_waitrequest, // Stall
   input wire apm_pkg::apm_src_t src_evt, // Detector event pulses
   input wire logic flags_read, // Flags register read pulse
   input wire logic dmic_clk, // Microphone clock level
   output logic dmic_data, // Microphone data bit
   output logic dmic_valid, // New microphone bit
   input wire logic bclk_dir_out, // Bit clock drives out
   input wire logic bclk_out, // Bit clock to drive
   output logic bclk_in, // Bit clock from pin
   input wire logic pad_in, // Pin level
   output logic pad_out, // Pin drive value
   output logic pad_oe, // Pin drive enable
   output logic irq // Level interrupt
);
   import apm_pkg::*;

   // ==========================================
   // Elaboration checks
   localparam int unsigned CNT_W = $clog2(PULSE_CYCLES + 1);
   if (PULSE_CYCLES < 1 || HS_CYCLES < 1 || HS_CYCLES > PULSE_CYCLES)
   begin : g_bad
      $error("apm_aux_pin: pulse lengths out of range");
   end

   // Source mask picked by each selector code
   function automatic logic [3:0] src_mask(input logic [3:0] sel);
      case (sel)
         SEL_HS: src_mask = 4'h1; // R3
         SEL_HS_BTN: src_mask = 4'h3; // R8
         SEL_ALL: src_mask = 4'hf; // R9
         SEL_SC_NZ: src_mask = 4'hc; // R10
         SEL_HS_BTN_SC: src_mask = 4'h7; // R11
         SEL_SC: src_mask = 4'h4; // R12
         SEL_NZ: src_mask = 4'h8; // R14
         SEL_BTN: src_mask = 4'h2; // R13
         default: src_mask = 4'h0;
      endcase
   endfunction

   // ==========================================
   // Registers
   logic [3:0] sel_q; // Function selector
   logic gpo_q; // Output value
   logic dur_q; // Repeat mode
   logic [3:0] stat_q; // Sticky events
   logic [3:0] mask_q; // Event mask
   logic ack_q; // Bus answer pending
   logic [7:0] idx; // Register index
   logic wr_en; // Write accepted this edge
   logic rd_en; // Read data load edge, one before acceptance
   logic gpi_val; // Filtered pin level
   logic is_int; // Interrupt function chosen
   logic trig; // Selected event this cycle

   assign idx = avs_address[9:2];
   assign wr_en = avs_write & ack_q & avs_byteenable[0];
   assign rd_en = avs_read & ~ack_q;
   assign is_int = (src_mask(sel_q) != 4'h0);
   assign trig = |(src_mask(sel_q) & src_evt);

   // One wait cycle: request taken at the second edge
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

   // Answer strobe, drops after each accepted transfer
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         ack_q <= 1'b0;
      else
         ack_q <= (avs_read | avs_write) & ~ack_q;
   end

   // Control register writes; D2 and D0 are not stored
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         sel_q <= CTRL_RST[7:4]; // R1
         gpo_q <= CTRL_RST[GPO_BIT];
         dur_q <= CTRL_RST[DUR_BIT];
      end
      else if (wr_en && idx == CTRL_IDX)
      begin
         sel_q <= avs_writedata[SEL_LSB +: 4];
         gpo_q <= avs_writedata[GPO_BIT];
         dur_q <= avs_writedata[DUR_BIT];
      end
   end

   // Mask register
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         mask_q <= MASK_RST;
      else if (wr_en && idx == MASK_IDX)
         mask_q <= avs_writedata[3:0];
   end

   // Sticky status; a new event beats a clear in the same cycle
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         stat_q <= STAT_RST;
      else if (wr_en && idx == STAT_IDX)
         stat_q <= (stat_q & ~avs_writedata[3:0]) | src_evt;
      else
         stat_q <= stat_q | src_evt;
   end

   assign irq = |(stat_q & mask_q);

   // Read mux; unmapped addresses read zero
   // Loaded at the first edge so the data stand at the accepting edge
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         avs_readdata <= 32'h0000_0000;
      else if (rd_en)
      begin
         case (idx)
            CTRL_IDX: avs_readdata <= {24'h00_0000, sel_q, gpo_q, gpi_val, dur_q, 1'b0}; // R4 R17
            STAT_IDX: avs_readdata <= {28'h000_0000, stat_q};
            MASK_IDX: avs_readdata <= {28'h000_0000, mask_q};
            default: avs_readdata <= 32'h0000_0000;
         endcase
      end
   end
   // ==========================================
   // Pin input synchroniser, three stages
   logic [2:0] pin_sync_q; // Stage 0 feeds stage 1 only
   logic pin_q; // Accepted pin level

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         pin_sync_q <= 3'h0;
      else
         pin_sync_q <= {pin_sync_q[1:0], pad_in};
   end

   // Change counts once second and third stage agree
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         pin_q <= 1'b0;
      else if (pin_sync_q[1] == pin_sync_q[2])
         pin_q <= pin_sync_q[2];
   end

   // Input value only meaningful in input mode
   assign gpi_val = (sel_q == SEL_GPI) ? pin_q : 1'b0; // R4

   // ==========================================
   // Microphone data, taken on both clock edges
   logic dmic_clk_q; // Previous microphone clock

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         dmic_clk_q <= 1'b0;
         dmic_data <= 1'b0;
         dmic_valid <= 1'b0;
      end
      else
      begin
         dmic_clk_q <= dmic_clk;
         dmic_valid <= 1'b0;
         // Any edge of the microphone clock samples the pin
         if (sel_q >= SEL_DMIC_LO && sel_q <= SEL_DMIC_HI && dmic_clk != dmic_clk_q)
         begin
            dmic_data <= pin_q; // R6
            dmic_valid <= 1'b1;
         end
      end
   end

   // Bit clock from the pin when it is an input
   assign bclk_in = (sel_q == SEL_BCLK && !bclk_dir_out) ? pin_q : 1'b0; // R7

   // ==========================================
   // Interrupt pulse generator
   typedef enum logic [1:0] {PG_IDLE, PG_HIGH, PG_LOW} apm_pg_t;
   apm_pg_t pg_q; // Pulse state
   logic [CNT_W-1:0] cnt_q; // Cycles left in phase
   logic [CNT_W-1:0] len; // Phase length for this code

   // Headset-only code uses its own shorter pulse
   assign len = (sel_q == SEL_HS) ? CNT_W'(HS_CYCLES) : CNT_W'(PULSE_CYCLES); // R3 R15

   // Single pulse, or repeating until the flags are read
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         pg_q <= PG_IDLE;
         cnt_q <= '0;
      end
      else if (!is_int)
      begin
         pg_q <= PG_IDLE; // Function left, drop any pulse
         cnt_q <= '0;
      end
      else
      begin
         case (pg_q)
            PG_IDLE:
               if (trig)
               begin
                  pg_q <= PG_HIGH;
                  cnt_q <= len - CNT_W'(1);
               end
            PG_HIGH:
               if (dur_q && flags_read)
                  pg_q <= PG_IDLE; // R16
               else if (cnt_q != '0)
                  cnt_q <= cnt_q - CNT_W'(1);
               else if (dur_q)
               begin
                  pg_q <= PG_LOW; // R16
                  cnt_q <= len - CNT_W'(1);
               end
               else
                  pg_q <= PG_IDLE; // R15
            PG_LOW:
               if (flags_read)
                  pg_q <= PG_IDLE; // R16
               else if (cnt_q != '0)
                  cnt_q <= cnt_q - CNT_W'(1);
               else
               begin
                  pg_q <= PG_HIGH;
                  cnt_q <= len - CNT_W'(1);
               end
            default:
               pg_q <= PG_IDLE;
         endcase
      end
   end

   // ==========================================
   // Pad driver; off for disabled, input and microphone codes
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         pad_out <= 1'b0;
         pad_oe <= 1'b0; // R1
      end
      else if (sel_q == SEL_GPO)
      begin
         pad_out <= gpo_q; // R5
         pad_oe <= 1'b1;
      end
      else if (sel_q == SEL_BCLK && bclk_dir_out)
      begin
         pad_out <= bclk_out; // R7
         pad_oe <= 1'b1;
      end
      else if (is_int)
      begin
         pad_out <= (pg_q == PG_HIGH); // R8 R9 R10 R11 R12 R13 R14
         pad_oe <= 1'b1;
      end
      else
      begin
         pad_out <= 1'b0; // R18
         pad_oe <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: shared/apm_pkg.sv
// Shared constants and types for the auxiliary pin function mux.
// Assumes a single 10 MHz clock and 32-bit Avalon-MM register access.
package apm_pkg;
   // ==========================================
   // Clock and timing
   localparam int unsigned CLK_PERIOD_NS = 100; // 10 MHz reference
   localparam int unsigned PULSE_NS = 2000000; // Single pulse, 2 ms
   localparam int unsigned HS_PULSE_NS = 1750000; // Headset-only pulse, 1.75 ms
   localparam int unsigned PULSE_CYC = PULSE_NS / CLK_PERIOD_NS; // Longest time, rounds down
   localparam int unsigned HS_PULSE_CYC = HS_PULSE_NS / CLK_PERIOD_NS;
   // ==========================================
   // Register map (index; byte address is four times it)
   localparam logic [7:0] CTRL_IDX = 8'h63; // aux_pin_control
   localparam logic [7:0] STAT_IDX = 8'h70; // Sticky event status
   localparam logic [7:0] MASK_IDX = 8'h71; // Event mask
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [3:0] STAT_RST = 4'h0;
   localparam logic [3:0] MASK_RST = 4'h0;
   // ==========================================
   // Control register fields
   localparam int SEL_LSB = 4; // Function selector D7..D4
   localparam int GPO_BIT = 3; // Output value
   localparam int GPI_BIT = 2; // Input value, read only
   localparam int DUR_BIT = 1; // Duration: 0 single, 1 repeat
   // ==========================================
   // Function selector codes
   localparam logic [3:0] SEL_OFF = 4'h0;
   localparam logic [3:0] SEL_RSVD = 4'h1;
   localparam logic [3:0] SEL_HS = 4'h2;
   localparam logic [3:0] SEL_GPI = 4'h3;
   localparam logic [3:0] SEL_GPO = 4'h4;
   localparam logic [3:0] SEL_DMIC_LO = 4'h5;
   localparam logic [3:0] SEL_DMIC_HI = 4'h7;
   localparam logic [3:0] SEL_BCLK = 4'h8;
   localparam logic [3:0] SEL_HS_BTN = 4'h9;
   localparam logic [3:0] SEL_ALL = 4'ha;
   localparam logic [3:0] SEL_SC_NZ = 4'hb;
   localparam logic [3:0] SEL_HS_BTN_SC = 4'hc;
   localparam logic [3:0] SEL_SC = 4'hd;
   localparam logic [3:0] SEL_NZ = 4'he;
   localparam logic [3:0] SEL_BTN = 4'hf;
   // ==========================================
   // Interrupt sources, one bit each
   typedef struct packed {
      logic noise; // Gain loop noise detect
      logic short_c; // Short-circuit detect
      logic button; // Button press / hook switch
      logic headset; // Jack / headset detect
   } apm_src_t;
endpackage

// File: tb/apm_assertions.sv
// Port checks for the auxiliary pin mux.
// Assumes one clock, synchronous low reset.
`timescale 1ns/10ps
`default_nettype none
module apm_assertions (
   input wire logic ref_clk, // Clock
   input wire logic rst_n, // Reset, low
   input wire logic avs_read, // Read
   input wire logic avs_write, // Write
   input wire logic avs_waitrequest, // Stall
   input wire apm_pkg::apm_src_t src_evt, // Events
   input wire logic dmic_clk, // Mic clock
   input wire logic dmic_valid, // Mic strobe
   input wire logic bclk_dir_out, // Clock out
   input wire logic bclk_in, // Clock in
   input wire logic pad_out, // Pin value
   input wire logic pad_oe, // Pin enable
   input wire logic irq // Interrupt
);
   import apm_pkg::*;
   // ==========
   // Common clock
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   logic req; // Any request
   assign req = avs_read | avs_write;
   AST_RST_IDLE: assert property ($rose(rst_n) |-> !pad_oe && !irq) else $error("pin live after reset");
   AST_ONE_WAIT: assert property ($rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("wait state count");
   AST_ACK_DROP: assert property (req && !avs_waitrequest |=> avs_waitrequest || !req)
      else $error("ack held");
   AST_IRQ_RISE: assert property ($rose(irq) |-> $past(src_evt) != 4'h0 || $past(avs_write))
      else $error("irq without cause");
   AST_IRQ_FALL: assert property ($fell(irq) |-> $past(avs_write)) else $error("irq lost");
   AST_BCLK_OE: assert property (bclk_in |=> !pad_oe) else $error("driving in input clock");
   AST_DMIC_OE: assert property (dmic_valid |-> !pad_oe) else $error("driving mic pin");
   AST_DMIC_EDGE: assert property (dmic_valid |-> $past(dmic_clk, 1) != $past(dmic_clk, 2) ||
      $past(dmic_clk, 2) != $past(dmic_clk, 3) || $past(dmic_clk, 3) != $past(dmic_clk, 4))
      else $error("mic bit without edge");
   AST_OE_CAUSE: assert property ($rose(pad_oe) |-> $past(avs_write, 2) || $past(bclk_dir_out))
      else $error("driver on without cause");
   // Main scenarios seen
   COV_PULSE: cover property (pad_oe && pad_out);
   COV_MIC: cover property (dmic_valid);
   COV_IRQ: cover property (irq);
endmodule
`default_nettype wire

// File: tb/apm_pin_model.sv
// Far side of the auxiliary pin: outside driver and wire.
// Assumes the bench drives only while the pin is undriven.
`timescale 1ns/10ps
`default_nettype none
module apm_pin_model (
   input wire logic ref_clk, // Clock
   input wire logic pad_out, // Device value
   input wire logic pad_oe, // Device enable
   input wire logic ext_en, // Outside driver on
   input wire logic ext_lvl, // Outside level
   output logic pad_in // Wire level
);
   logic last_q = 1'b0; // Last level driven onto the wire
   // No pull here: an idle wire shows the opposite of its last driven level
   always_ff @(posedge ref_clk)
   begin
      if (pad_oe)
         last_q <= pad_out;
      else if (ext_en)
         last_q <= ext_lvl;
   end
   assign pad_in = pad_oe ? pad_out : (ext_en ? ext_lvl : ~last_q);
endmodule
`default_nettype wire

// File: tb/apm_aux_pin_tb.sv
// Self-checking bench for the auxiliary pin mux.
// Assumes package, design, model and checker compiled first.
`timescale 1ns/10ps
`default_nettype none
module apm_aux_pin_tb;
   import apm_pkg::*;
   localparam int PL = 20; // Short 2 ms pulse
   localparam int HL = 17; // Short headset pulse
   localparam logic [9:0] CA = {CTRL_IDX, 2'b00};
   localparam logic [9:0] SA = {STAT_IDX, 2'b00};
   localparam logic [9:0] MA = {MASK_IDX, 2'b00};
   logic ref_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest, irq;
   logic [9:0] avs_address = '0;
   logic [31:0] avs_writedata = '0, avs_readdata, q;
   logic [3:0] avs_byteenable = 4'hf;
   logic flags_read = 0, dmic_clk = 0, dmic_data, dmic_valid, bclk_dir_out = 0, bclk_out = 0, bclk_in;
   logic pad_in, pad_out, pad_oe, ext_en = 0, ext_lvl = 0;
   apm_src_t src_evt = '0;
   int miscompares = 0, samples_checked = 0;
   always #50 ref_clk = ~ref_clk;
   apm_aux_pin #(.PULSE_CYCLES(PL), .HS_CYCLES(HL)) uut (
      .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .src_evt(src_evt),
      .flags_read(flags_read), .dmic_clk(dmic_clk), .dmic_data(dmic_data), .dmic_valid(dmic_valid),
      .bclk_dir_out(bclk_dir_out), .bclk_out(bclk_out), .bclk_in(bclk_in), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe(pad_oe), .irq(irq));
   apm_pin_model u_pin (.ref_clk(ref_clk), .pad_out(pad_out), .pad_oe(pad_oe), .ext_en(ext_en),
      .ext_lvl(ext_lvl), .pad_in(pad_in));
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, e);
      samples_checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // Avalon access, held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
      int i;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= w;
      avs_read <= ~w;
      for (i = 0; i < 20; i++)
      begin
         @(posedge ref_clk);
         if (avs_waitrequest === 1'b0)
            break;
      end
      if (i == 20)
      begin
         chk(1'b1, 1'b0);
         wrap_up();
      end
      // Accepting edge: take read data here, then release
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic nb(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic pin(input logic e, v);
      @(posedge ref_clk);
      ext_en <= e;
      ext_lvl <= v;
   endtask
   task automatic evt(input logic [3:0] s);
      @(posedge ref_clk);
      src_evt <= s;
      @(posedge ref_clk);
      src_evt <= '0;
   endtask
   task automatic rises(input int n, output int k);
      logic p;
      p = pad_out;
      k = 0;
      repeat (n)
      begin
         @(negedge ref_clk);
         k += int'(pad_out && !p);
         p = pad_out;
      end
   endtask
   task automatic t_gpio();
      bus(1'b0, CA, 8'h0);
      chk(q, {24'h0, CTRL_RST});
      bus(1'b0, 10'h000, 8'h0);
      chk(q, 32'h0);
      bus(1'b1, CA, {SEL_GPO, 4'h8});
      nb(2);
      chk({pad_oe, pad_out}, 2'b11);
      bus(1'b1, CA, {SEL_GPO, 4'h0});
      nb(2);
      chk({pad_oe, pad_out}, 2'b10);
      bus(1'b1, CA, {SEL_GPI, 4'h0});
      pin(1'b1, 1'b1);
      nb(6);
      bus(1'b0, CA, 8'h0);
      chk(q, {24'h0, SEL_GPI, 4'h4});
      chk(pad_oe, 1'b0);
      pin(1'b1, 1'b0);
      nb(6);
      bus(1'b0, CA, 8'h0);
      chk(q, {24'h0, SEL_GPI, 4'h0});
      pin(1'b0, 1'b0);
   endtask
   // Every interrupt code against every source
   task automatic t_codes();
      logic [3:0] cl [9] = '{4'h0, 4'h2, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
      logic [3:0] ms [9] = '{4'h0, 4'h1, 4'h3, 4'hf, 4'hc, 4'h7, 4'h4, 4'h8, 4'h2};
      int c, s, k;
      for (c = 0; c < 9; c++)
         for (s = 0; s < 4; s++)
         begin
            bus(1'b1, CA, {cl[c], 4'h0});
            evt(4'h1 << s);
            k = 0;
            repeat (PL + 8)
            begin
               @(negedge ref_clk);
               k += int'((pad_oe && pad_out) === 1'b1);
            end
            chk(k, ms[c][s] ? (cl[c] == 4'h2 ? HL : PL) : 0);
         end
   endtask
   task automatic t_repeat();
      int k;
      bus(1'b1, CA, {SEL_ALL, 4'h2});
      evt(4'h8);
      rises(5 * PL, k);
      chk(k, 3);
      @(posedge ref_clk);
      flags_read <= 1'b1;
      @(posedge ref_clk);
      flags_read <= 1'b0;
      nb(2 * PL + 4);
      rises(3 * PL, k);
      chk(k, 0);
   endtask
   task automatic t_pins();
      int k, c;
      bus(1'b1, CA, {SEL_BCLK, 4'h0});
      @(posedge ref_clk);
      bclk_dir_out <= 1'b1;
      bclk_out <= 1'b1;
      nb(3);
      chk({pad_oe, pad_out}, 2'b11);
      @(posedge ref_clk);
      bclk_dir_out <= 1'b0;
      pin(1'b1, 1'b1);
      nb(6);
      chk({pad_oe, bclk_in}, 2'b01);
      for (c = 5; c < 8; c++)
      begin
         bus(1'b1, CA, {c[3:0], 4'h0});
         nb(8);
         k = 0;
         repeat (2)
         begin
            @(posedge ref_clk);
            dmic_clk <= ~dmic_clk;
            repeat (8)
            begin
               @(negedge ref_clk);
               k += int'(dmic_valid === 1'b1);
            end
         end
         chk(k, 2);
         chk(dmic_data, 1'b1);
      end
      pin(1'b0, 1'b0);
   endtask
   task automatic t_irq();
      bus(1'b1, CA, 8'h00);
      bus(1'b1, SA, 8'h0f);
      evt(4'h5);
      nb(2);
      chk(irq, 1'b0);
      bus(1'b0, SA, 8'h0);
      chk(q, 32'h5);
      bus(1'b1, MA, 8'h04);
      nb(1);
      chk(irq, 1'b1);
      bus(1'b1, SA, 8'h04);
      nb(1);
      chk(irq, 1'b0);
      bus(1'b0, SA, 8'h0);
      chk(q, 32'h1);
   endtask
   initial
   begin
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_gpio();
      t_codes();
      t_repeat();
      t_pins();
      t_irq();
      wrap_up();
   end
endmodule
bind apm_aux_pin apm_assertions u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .src_evt(src_evt), .dmic_clk(dmic_clk),
   .dmic_valid(dmic_valid), .bclk_dir_out(bclk_dir_out), .bclk_in(bclk_in), .pad_out(pad_out),
   .pad_oe(pad_oe), .irq(irq));
`default_nettype wire
